/* logic/pfs_top.sv */
// pin function select: config registers for pins 3 to 6, spi override of pins 4 to 6, pin 1 current-sense toggle enable
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module pfs_top #(
  parameter int unsigned NPINS = pfs_pkg::NUM_PINS
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  // register port
  input  wire logic [pfs_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [pfs_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [pfs_pkg::DATA_W-1:0]  reg_rdata,
  // spi master engine side
  input  wire logic                        spi_mosi,
  input  wire logic                        spi_sclk,
  output logic                             spi_en,
  output logic                             spi_miso,
  // pin 1 current-sense toggle
  output logic                             pin1_cs_toggle_en,
  // pads for pins 3..6, bit 0 is pin 3
  input  wire logic [pfs_pkg::NUM_PINS-1:0] pad_in,
  output logic      [pfs_pkg::NUM_PINS-1:0] pad_oe,
  output logic      [pfs_pkg::NUM_PINS-1:0] pad_out,
  output logic      [pfs_pkg::NUM_PINS-1:0] pad_in_en,
  output logic      [pfs_pkg::NUM_PINS-1:0] adc_en,
  output logic      [pfs_pkg::NUM_PINS-1:0] temp_cmp_en,
  output logic      [pfs_pkg::NUM_PINS-1:0] pull_up,
  output logic      [pfs_pkg::NUM_PINS-1:0] pull_down,
  output logic      [pfs_pkg::NUM_PINS-1:0] dig_in
);
  import pfs_pkg::*;

  localparam int unsigned FIELD_W  = 3;
  localparam int unsigned SCLK_IDX = 4 - FIRST_PIN;
  localparam int unsigned MISO_IDX = 5 - FIRST_PIN;
  localparam int unsigned MOSI_IDX = 6 - FIRST_PIN;

  logic [1:0]        rst_sync_q;
  logic              rst_n;
  logic [7:0]        cfg_b_q;
  logic [7:0]        cfg_c_q;
  logic [7:0]        ctrl_q;
  logic [7:0]        rdata_q;
  logic [NPINS-1:0]  in_meta_q;
  logic [NPINS-1:0]  in_sync_q;
  logic [2:0]        func [NPINS];
  logic [NPINS-1:0]  spi_own;
  logic [NPINS-1:0]  spi_oe;
  logic [NPINS-1:0]  spi_drv;
  logic [NPINS-1:0]  oe_c;
  logic [NPINS-1:0]  out_c;
  logic [NPINS-1:0]  ien_c;
  logic [NPINS-1:0]  adc_c;
  logic [NPINS-1:0]  tmp_c;
  logic [NPINS-1:0]  pu_c;
  logic [NPINS-1:0]  pd_c;
  logic              miso_q;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // write strobe aimed at one register
  function automatic logic wr_hit(input logic              wr,
                                  input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] target);
    return wr && (addr == target);
  endfunction

  // pin 3 and 4 fields and current-sense toggle enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_b_q <= CFG_B_RESET;
    end else if (wr_hit(reg_wr, reg_addr, CFG_B_ADDR)) begin
      cfg_b_q <= reg_wdata & CFG_B_MASK;
    end
  end

  // pin 5 and 6 fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_c_q <= CFG_C_RESET;
    end else if (wr_hit(reg_wr, reg_addr, CFG_C_ADDR)) begin
      cfg_c_q <= reg_wdata & CFG_C_MASK;
    end
  end

  // serial-host enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_hit(reg_wr, reg_addr, CTRL_ADDR)) begin
      ctrl_q <= reg_wdata & CTRL_MASK;
    end
  end

  // pad input synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_q <= '0;
      in_sync_q <= '0;
    end else begin
      in_meta_q <= pad_in;
      in_sync_q <= in_meta_q;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= ZERO_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        CFG_B_ADDR:  rdata_q <= cfg_b_q;
        CFG_C_ADDR:  rdata_q <= cfg_c_q;
        CTRL_ADDR:   rdata_q <= ctrl_q;
        STATUS_ADDR: rdata_q <= {{(8-NPINS){1'b0}}, in_sync_q};
        default:     rdata_q <= ZERO_BYTE;
      endcase
    end else begin
      rdata_q <= ZERO_BYTE;
    end
  end
  assign reg_rdata = rdata_q;

  assign spi_en            = ctrl_q[SPI_EN_BIT];
  assign pin1_cs_toggle_en = cfg_b_q[CS_TOGGLE_BIT];

  genvar gi;

  // function field per pin, two fields to a config byte; index 0 = pin 3
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_field
      if (gi < NPINS / 2) begin : g_lo_byte
        assign func[gi] = cfg_b_q[((gi % 2) != 0 ? HI_FIELD_LSB : LO_FIELD_LSB) +: FIELD_W];
      end else begin : g_hi_byte
        assign func[gi] = cfg_c_q[((gi % 2) != 0 ? HI_FIELD_LSB : LO_FIELD_LSB) +: FIELD_W];
      end
    end
  endgenerate

  // spi roles: pin 4 clock out, pin 5 data in, pin 6 data out; pin 3 never taken over
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_spi
      if (gi == SCLK_IDX || gi == MOSI_IDX) begin : g_drive
        assign spi_own[gi] = spi_en;
        assign spi_oe[gi]  = 1'b1;
        assign spi_drv[gi] = (gi == MOSI_IDX) ? spi_mosi : spi_sclk;
      end else if (gi == MISO_IDX) begin : g_sense
        assign spi_own[gi] = spi_en;
        assign spi_oe[gi]  = 1'b0;
        assign spi_drv[gi] = 1'b0;
      end else begin : g_free
        assign spi_own[gi] = 1'b0;
        assign spi_oe[gi]  = 1'b0;
        assign spi_drv[gi] = 1'b0;
      end
    end
  endgenerate

  // miso level handed to the spi engine, pin 5 only while the master owns it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= spi_en & in_sync_q[MISO_IDX];
    end
  end
  assign spi_miso = miso_q;

  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      pfs_pin_cell u_cell (
        .func        (func[gi]),
        .spi_own     (spi_own[gi]),
        .spi_oe      (spi_oe[gi]),
        .spi_out     (spi_drv[gi]),
        .pad_oe      (oe_c[gi]),
        .pad_out     (out_c[gi]),
        .pad_in_en   (ien_c[gi]),
        .adc_en      (adc_c[gi]),
        .temp_cmp_en (tmp_c[gi]),
        .pull_up     (pu_c[gi]),
        .pull_down   (pd_c[gi])
      );
    end
  endgenerate

  // registered pad controls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_oe      <= '0;
      pad_out     <= '0;
      pad_in_en   <= '0;
      adc_en      <= '0;
      temp_cmp_en <= '0;
      pull_up     <= '0;
      pull_down   <= '0;
      dig_in      <= '0;
    end else begin
      pad_oe      <= oe_c;
      pad_out     <= out_c;
      pad_in_en   <= ien_c;
      adc_en      <= adc_c;
      temp_cmp_en <= tmp_c;
      pull_up     <= pu_c;
      pull_down   <= pd_c;
      dig_in      <= in_sync_q & ien_c;
    end
  end
endmodule

/* logic/pfs_pkg.sv */
// package: register map, field layout and pin function codes for the pin function select block
package pfs_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [15:0] CFG_B_ADDR    = 16'h000F;
  localparam logic [15:0] CFG_C_ADDR    = 16'h0010;
  localparam logic [15:0] CTRL_ADDR     = 16'h0012;
  localparam logic [15:0] STATUS_ADDR   = 16'h0013;
  localparam logic [7:0]  CFG_B_RESET   = 8'h00;
  localparam logic [7:0]  CFG_C_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam int unsigned LO_FIELD_LSB  = 0;
  localparam int unsigned HI_FIELD_LSB  = 3;
  localparam int unsigned CS_TOGGLE_BIT = 6;
  localparam int unsigned SPI_EN_BIT    = 0;
  localparam int unsigned NUM_PINS      = 4;
  localparam int unsigned FIRST_PIN     = 3;
  localparam logic [7:0]  CFG_B_MASK    = 8'h7F;
  localparam logic [7:0]  CFG_C_MASK    = 8'h3F;
  localparam logic [7:0]  CTRL_MASK     = 8'h01;

  typedef enum logic [2:0] {
    PFS_HIGH_Z      = 3'h0,
    PFS_ADC_TEMP    = 3'h1,
    PFS_ADC_ONLY    = 3'h2,
    PFS_DIG_IN      = 3'h3,
    PFS_OUT_HIGH    = 3'h4,
    PFS_OUT_LOW     = 3'h5,
    PFS_ADC_PULLUP  = 3'h6,
    PFS_ADC_PULLDN  = 3'h7
  } pfs_func_t;
endpackage

/* logic/pfs_pin_cell.sv */
// one pin: decodes a 3-bit function field into pad controls, with spi override
`timescale 1ns/1ps
module pfs_pin_cell (
  // function select
  input  wire logic [2:0] func,
  input  wire logic       spi_own,
  input  wire logic       spi_oe,
  input  wire logic       spi_out,
  // pad controls
  output logic            pad_oe,
  output logic            pad_out,
  output logic            pad_in_en,
  output logic            adc_en,
  output logic            temp_cmp_en,
  output logic            pull_up,
  output logic            pull_down
);
  import pfs_pkg::*;

  always_comb begin
    pad_oe      = 1'b0;
    pad_out     = 1'b0;
    pad_in_en   = 1'b0;
    adc_en      = 1'b0;
    temp_cmp_en = 1'b0;
    pull_up     = 1'b0;
    pull_down   = 1'b0;
    if (spi_own) begin
      pad_oe    = spi_oe;
      pad_out   = spi_out;
      pad_in_en = ~spi_oe;
    end else begin
      unique case (pfs_func_t'(func))
        PFS_HIGH_Z: ;
        PFS_ADC_TEMP: begin
          adc_en      = 1'b1;
          temp_cmp_en = 1'b1;
        end
        PFS_ADC_ONLY: adc_en = 1'b1;
        PFS_DIG_IN:   pad_in_en = 1'b1;
        PFS_OUT_HIGH: begin
          pad_oe  = 1'b1;
          pad_out = 1'b1;
        end
        PFS_OUT_LOW:  pad_oe = 1'b1;
        PFS_ADC_PULLUP: begin
          adc_en  = 1'b1;
          pull_up = 1'b1;
        end
        PFS_ADC_PULLDN: begin
          adc_en    = 1'b1;
          pull_down = 1'b1;
        end
      endcase
    end
  end
endmodule

/* sim/pfs_checker.sv */
// checker: pad decode, spi override and toggle-enable assertions
`timescale 1ns/1ps
module pfs_checker (
  // watched ports
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        spi_en,
  input wire logic        spi_mosi,
  input wire logic        pin1_cs_toggle_en,
  input wire logic [3:0]  pad_oe,
  input wire logic [3:0]  pad_out,
  input wire logic [3:0]  pad_in_en,
  input wire logic [3:0]  adc_en,
  input wire logic [3:0]  temp_cmp_en,
  input wire logic [3:0]  pull_up,
  input wire logic [3:0]  pull_down
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic wb;
  assign wb = reg_wr && reg_addr == 16'h000F;
  a_hiz_code: assert property (wb && reg_wdata[2:0] == 3'h0 ##1 !reg_wr |-> ##1
    !pad_oe[0] && !adc_en[0] && !pad_in_en[0]) else $error("pin3 not idle");
  a_temp_code: assert property (wb && reg_wdata[2:0] == 3'h1 ##1 !reg_wr |-> ##1
    adc_en[0] && temp_cmp_en[0]) else $error("pin3 no comparator");
  a_adc_only: assert property (wb && reg_wdata[2:0] == 3'h2 ##1 !reg_wr |-> ##1
    adc_en[0] && !temp_cmp_en[0]) else $error("pin3 not converter only");
  a_dig_code: assert property (wb && reg_wdata[2:0] == 3'h3 ##1 !reg_wr |-> ##1
    pad_in_en[0] && !adc_en[0]) else $error("pin3 not digital in");
  a_out_level: assert property (wb && reg_wdata[2:1] == 2'h2 ##1 !reg_wr |-> ##1
    pad_oe[0] && pad_out[0] != $past(reg_wdata[0], 2)) else $error("pin3 bad level");
  a_pull_dir: assert property (wb && reg_wdata[2:1] == 2'h3 ##1 !reg_wr |-> ##1
    pull_down[0] == $past(reg_wdata[0], 2) && pull_up[0] != pull_down[0])
    else $error("pin3 bad pull");
  a_mosi_route: assert property ((spi_en && spi_mosi)[*4] |-> pad_oe[3] && pad_out[3])
    else $error("pin6 not mosi");
  a_miso_in: assert property (spi_en[*4] |-> !pad_oe[2] && pad_in_en[2])
    else $error("pin5 not miso");
  a_sclk_pin: assert property (spi_en[*4] |-> pad_oe[1]) else $error("pin4 not driven");
  a_cs_toggle: assert property (wb ##1 !reg_wr |-> ##1
    pin1_cs_toggle_en == $past(reg_wdata[6], 2)) else $error("toggle enable wrong");
endmodule
bind pfs_top pfs_checker chk_u (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .spi_en,
  .spi_mosi, .pin1_cs_toggle_en, .pad_oe, .pad_out, .pad_in_en, .adc_en, .temp_cmp_en,
  .pull_up, .pull_down);

/* sim/pin_function_select_tb.sv */
// self-checking bench for the pin function select block
`timescale 1ns/1ps
module pin_function_select_tb;
  import pfs_pkg::*;
  logic        sys_clk, arst_n, reg_wr, reg_rd, spi_mosi, spi_sclk, spi_en, miso, cs1;
  logic        rd_p1, probe;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, b, d;
  logic [3:0]  pad_in, oe, po, ie, ae, te, pu, pd, di, dm;
  logic [7:0]  rq[$];
  logic [17:0] pq[$], e;
  int          errors = 0;
  int          check_count = 0;
  localparam logic [6:0] DEC [8] = '{7'h00, 7'h0C, 7'h08, 7'h10, 7'h60, 7'h40, 7'h0A, 7'h09};
  pfs_top dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .spi_mosi(spi_mosi), .spi_sclk(spi_sclk), .spi_en(spi_en), .spi_miso(miso),
    .pin1_cs_toggle_en(cs1), .pad_in(pad_in), .pad_oe(oe), .pad_out(po), .pad_in_en(ie),
    .adc_en(ae), .temp_cmp_en(te), .pull_up(pu), .pull_down(pd), .dig_in(di));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] v);
    rq.push_back(v);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic pr(input logic [1:0] p, input logic [7:0] v, input logic [7:0] m);
    pq.push_back({p, m, v});
    repeat (2) @(posedge sys_clk);
    probe <= 1'b1;
    @(posedge sys_clk);
    probe <= 1'b0;
  endtask
  function automatic logic [7:0] pv(input logic [1:0] p);
    return {cs1, oe[p], po[p], ie[p], ae[p], te[p], pu[p], pd[p]};
  endfunction
  always @(posedge sys_clk) begin
    if (rd_p1) chk(reg_rdata, rq.pop_front());
    if (probe) begin
      e = pq.pop_front();
      chk(pv(e[17:16]) & e[15:8], e[7:0] & e[15:8]);
    end
    rd_p1 <= reg_rd;
  end
  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    complete_run();
  end
  initial begin
    {reg_wr, reg_rd, probe, spi_mosi, spi_sclk, arst_n, pad_in, reg_addr, reg_wdata} = '0;
    void'($urandom(32'h786D8858));
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(16'h0011, 8'hFF);
    rd(CFG_B_ADDR, 8'h00);
    rd(CFG_C_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h00);
    rd(16'h0011, 8'h00);
    $display("reset and unmapped test done");
    for (int c = 0; c < 8; c++) begin
      b = 8'($urandom);
      d = 8'($urandom);
      b[5:0] = {3'(c + 1), 3'(c)};
      d[5:0] = {3'(c + 3), 3'(c + 2)};
      pad_in <= 4'($urandom);
      wr(CFG_B_ADDR, b);
      wr(CFG_C_ADDR, d);
      rd(CFG_B_ADDR, b & CFG_B_MASK);
      rd(CFG_C_ADDR, d & CFG_C_MASK);
      rd(STATUS_ADDR, {4'h0, pad_in});
      for (int p = 0; p < 4; p++) pr(2'(p), {b[6], DEC[3'(c + p)]}, 8'hFF);
      for (int p = 0; p < 4; p++) dm[p] = (3'(c + p) == PFS_DIG_IN) && pad_in[p];
      chk({4'h0, di}, {4'h0, dm});
    end
    $display("function code test done");
    b = 8'($urandom);
    {spi_mosi, spi_sclk} <= b[1:0];
    wr(CTRL_ADDR, 8'hFF);
    rd(CTRL_ADDR, 8'h01);
    for (int k = 0; k < 2; k++) begin
      pr(2'd1, {2'b01, b[0], 5'h00}, 8'h7F);
      pr(2'd2, 8'h10, 8'h7F);
      pr(2'd3, {2'b01, b[1], 5'h00}, 8'h7F);
      pr(2'd0, {1'b0, DEC[7]}, 8'h7F);
      chk({7'h00, miso}, {7'h00, pad_in[2]});
      chk({7'h00, spi_en}, 8'h01);
      b[1:0] = ~b[1:0];
      {spi_mosi, spi_sclk} <= b[1:0];
      pad_in <= ~pad_in;
    end
    wr(CTRL_ADDR, 8'h00);
    pr(2'd3, {1'b0, DEC[2]}, 8'h7F);
    chk({7'h00, miso}, 8'h00);
    $display("serial override test done");
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(CFG_C_ADDR, 8'h00);
    pr(2'd0, 8'h00, 8'hFF);
    $display("second reset test done");
    complete_run();
  end
endmodule
